// *** event_source_model.sv ***
// far-side model: event source that drives the event pin
module event_source (
  input wire pclk, // clock
  input wire go, // start one pulse
  output logic pin // event pin level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] t_r = 4'h0;
  // pulse stays high twelve cycles, so both edges are well apart
  always @(posedge pclk)
    if (go)
      t_r <= 4'hC;
    else if (t_r != 4'h0)
      t_r <= t_r - 4'h1;
  assign pin = (t_r != 4'h0);
endmodule // event_source

// *** event_timer_capture_output.v ***
// 8-bit event timer with reload, event count, pin output and input capture
//
// Behaviour
// - upper write loads counter, ticks increment it
// - overflow reloads or restarts from zero
// - irq flag cleared by software, reset, stop
// - clock select seven counts event pin edges
// - edge select picks falling, rising or both
// - output mode drives timer output on pin
// - trigger captures count, sets flags, clears counter
// - trigger or overflow while captured sets error
// - capture flags cleared by reset or zero write
// - capture mode returns pin, clears counter
// - mode register: reload bit, seven periods, event
// - mode register cleared by reset and stop
// - mode write takes effect two instruction cycles later
// - output mode register read/write, cleared reset/stop
// - captured value stable for either digit order
// - write register two digits, upper not reset
// - read register shares addresses, read-only
// - low write holds counter, upper write loads
// - upper read latches lower digit of count
// - toggle output inverts at overflow tick
// - low/high output at overflow, pin low after reset
`include "event_timer_consts.vh"

module event_timer_capture_output (
  input wire pclk, // system clock
  input wire presetn, // async reset, active low
  input wire [7:0] paddr, // apb byte address
  input wire psel, // apb select
  input wire penable, // apb enable
  input wire pwrite, // apb direction
  input wire [31:0] pwdata, // apb write data
  output reg [31:0] prdata, // apb read data
  output reg pready, // apb ready
  output reg pslverr, // apb error on unmapped address
  input wire stop_mode, // stop mode level
  input wire event_trigger_pin, // external event or trigger pin
  input wire shared_port_bit, // port latch value for shared pin
  output reg timer_output_pin, // shared output pin level
  output reg counter_irq_flag // timer interrupt request flag
);

////////////////////////////////////////////////////////////////////////////////
// declarations

reg [3:0] mode_r;
reg [3:0] mode_pend_r;
reg [1:0] pend_cnt_r;
reg [3:0] out_mode_r;
reg [3:0] edge_sel_r;
reg [3:0] port_func_r;
reg [3:0] data_low_r;
reg [3:0] data_high_r;
reg [3:0] rd_low_latch_r;
reg [7:0] capt_r;
reg [7:0] count_r;
reg [7:0] count_nxt;
reg [10:0] presc_r;
reg [1:0] tcyc_cnt_r;
reg tcyc_tick_r;
reg capt_status_r;
reg capt_error_r;
reg ev_sync1_r;
reg ev_sync2_r;
reg ev_prev_r;
reg [31:0] rdata_nxt;
reg mapped;
wire [5:0] idx;
wire access;
wire wr_done;
wire rd_access;
wire capture_mode;
wire event_clock;
wire pin_enabled;
wire ev_rise;
wire ev_fall;
wire ev_edge;
wire presc_tick;
wire cnt_tick;
wire trigger;
wire overflow;
wire load_count;
wire enter_capture;
wire [7:0] preset;

////////////////////////////////////////////////////////////////////////////////
// helpers

// prescaler tap for a clock select code
function presc_hit;
  input [2:0] sel;
  input [10:0] p;
  begin
    case (sel)
      3'h0: presc_hit = &p[10:0];
      3'h1: presc_hit = &p[8:0];
      3'h2: presc_hit = &p[6:0];
      3'h3: presc_hit = &p[4:0];
      3'h4: presc_hit = &p[2:0];
      3'h5: presc_hit = &p[1:0];
      3'h6: presc_hit = p[0];
      default: presc_hit = 1'b0;
    endcase
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// apb decode

assign idx = paddr[7:2];
assign access = psel & penable & ~pready;
assign wr_done = psel & penable & pready & pwrite;
assign rd_access = access & ~pwrite;

always @*
begin
  case (idx)
    `IDX_IRQ_FLAG, `IDX_MODE, `IDX_DATA_LOW, `IDX_DATA_HIGH, `IDX_OUT_MODE,
    `IDX_CAPT_FLAGS, `IDX_PORT_FUNC, `IDX_EDGE_SEL: mapped = 1'b1;
    default: mapped = 1'b0;
  endcase
end

// read-only digits share the write-only digit addresses
always @*
begin
  rdata_nxt = 32'h00000000;
  case (idx)
    `IDX_IRQ_FLAG: rdata_nxt[`IRQ_FLAG_BIT] = counter_irq_flag;
    `IDX_DATA_LOW: rdata_nxt[3:0] = capture_mode ? capt_r[3:0] : rd_low_latch_r;
    `IDX_DATA_HIGH: rdata_nxt[3:0] = capture_mode ? capt_r[7:4] : count_r[7:4];
    `IDX_OUT_MODE: rdata_nxt[3:0] = out_mode_r;
    `IDX_CAPT_FLAGS:
    begin
      rdata_nxt[`CAPT_STATUS_BIT] = capt_status_r;
      rdata_nxt[`CAPT_ERROR_BIT] = capt_error_r;
    end
    default: rdata_nxt = 32'h00000000;
  endcase
end

// one wait state, answer from flops
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    pready <= 1'b0;
    prdata <= 32'h00000000;
    pslverr <= 1'b0;
  end
  else
  begin
    pready <= access;
    prdata <= rd_access ? rdata_nxt : 32'h00000000;
    pslverr <= access & ~mapped;
  end
end

////////////////////////////////////////////////////////////////////////////////
// instruction cycle and prescaler

always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    tcyc_cnt_r <= 2'h0;
    tcyc_tick_r <= 1'b0;
    presc_r <= 11'h000;
  end
  else
  begin
    tcyc_tick_r <= (tcyc_cnt_r == `TCYC_LAST);
    tcyc_cnt_r <= (tcyc_cnt_r == `TCYC_LAST) ? 2'h0 : tcyc_cnt_r + 2'h1;
    if (tcyc_tick_r)
      presc_r <= presc_r + 11'h001;
  end
end

assign presc_tick = tcyc_tick_r & presc_hit(mode_r[2:0], presc_r);

////////////////////////////////////////////////////////////////////////////////
// event pin sync and edge detect

always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    ev_sync1_r <= 1'b0;
    ev_sync2_r <= 1'b0;
    ev_prev_r <= 1'b0;
  end
  else
  begin
    ev_sync1_r <= event_trigger_pin;
    ev_sync2_r <= ev_sync1_r;
    ev_prev_r <= ev_sync2_r;
  end
end

assign ev_rise = ev_sync2_r & ~ev_prev_r;
assign ev_fall = ~ev_sync2_r & ev_prev_r;
assign pin_enabled = port_func_r[`PORT_EVENT_EN_BIT];
assign ev_edge = pin_enabled & (
  (ev_rise & edge_sel_r[3]) | (ev_fall & edge_sel_r[2]));

////////////////////////////////////////////////////////////////////////////////
// control registers

always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    mode_r <= `MODE_RST;
    mode_pend_r <= `MODE_RST;
    pend_cnt_r <= 2'h0;
    out_mode_r <= `OUT_MODE_RST;
    edge_sel_r <= `EDGE_SEL_RST;
    port_func_r <= `PORT_FUNC_RST;
    data_low_r <= `DATA_LOW_RST;
  end
  else if (stop_mode)
  begin
    mode_r <= `MODE_RST;
    mode_pend_r <= `MODE_RST;
    pend_cnt_r <= 2'h0;
    out_mode_r <= `OUT_MODE_RST;
    edge_sel_r <= `EDGE_SEL_RST;
    port_func_r <= `PORT_FUNC_RST;
    data_low_r <= `DATA_LOW_RST;
  end
  else
  begin
    if (wr_done && idx == `IDX_MODE)
    begin
      mode_pend_r <= pwdata[3:0];
      pend_cnt_r <= `MODE_DELAY_TCYC;
    end
    else if (tcyc_tick_r && pend_cnt_r != 2'h0)
    begin
      pend_cnt_r <= pend_cnt_r - 2'h1;
      if (pend_cnt_r == 2'h1)
        mode_r <= mode_pend_r;
    end
    if (wr_done && idx == `IDX_OUT_MODE)
      out_mode_r <= pwdata[3:0];
    if (wr_done && idx == `IDX_EDGE_SEL)
      edge_sel_r <= pwdata[3:0];
    if (wr_done && idx == `IDX_PORT_FUNC)
      port_func_r <= pwdata[3:0];
    if (wr_done && idx == `IDX_DATA_LOW)
      data_low_r <= pwdata[3:0];
  end
end

// upper preset digit has no reset
always @(posedge pclk)
begin
  if (wr_done && idx == `IDX_DATA_HIGH)
    data_high_r <= pwdata[3:0];
end

////////////////////////////////////////////////////////////////////////////////
// counter

assign capture_mode = (out_mode_r == `OUT_CAPTURE);
assign event_clock = (mode_r[2:0] == `SEL_EVENT) & ~capture_mode;
assign cnt_tick = event_clock ? ev_edge : presc_tick;
assign trigger = capture_mode & ev_edge;
assign overflow = cnt_tick & (count_r == `COUNT_MAX);
assign load_count = wr_done & (idx == `IDX_DATA_HIGH);
assign enter_capture = wr_done & (idx == `IDX_OUT_MODE) & (pwdata[3:0] == `OUT_CAPTURE);
assign preset = {data_high_r, data_low_r};

always @*
begin
  count_nxt = count_r;
  if (enter_capture)
    count_nxt = `COUNT_ZERO;
  else if (load_count)
    count_nxt = {pwdata[3:0], data_low_r};
  else if (trigger)
    count_nxt = `COUNT_ZERO;
  else if (overflow)
    count_nxt = (mode_r[`MODE_RELOAD_BIT] && !capture_mode) ? preset : `COUNT_ZERO;
  else if (cnt_tick)
    count_nxt = count_r + 8'h01;
end

always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    count_r <= `COUNT_ZERO;
    capt_r <= `COUNT_ZERO;
    rd_low_latch_r <= 4'h0;
  end
  else
  begin
    count_r <= count_nxt;
    if (trigger)
      capt_r <= count_r;
    if (rd_access && idx == `IDX_DATA_HIGH)
      rd_low_latch_r <= count_r[3:0];
  end
end

////////////////////////////////////////////////////////////////////////////////
// flags, set wins over clear

always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    counter_irq_flag <= 1'b0;
    capt_status_r <= 1'b0;
    capt_error_r <= 1'b0;
  end
  else
  begin
    if (trigger || (overflow && !capture_mode))
      counter_irq_flag <= 1'b1;
    else if (stop_mode)
      counter_irq_flag <= 1'b0;
    else if (wr_done && idx == `IDX_IRQ_FLAG && !pwdata[`IRQ_FLAG_BIT])
      counter_irq_flag <= 1'b0;
    if (trigger)
      capt_status_r <= 1'b1;
    else if (wr_done && idx == `IDX_CAPT_FLAGS && !pwdata[`CAPT_STATUS_BIT])
      capt_status_r <= 1'b0;
    if (capt_status_r && (trigger || (overflow && capture_mode)))
      capt_error_r <= 1'b1;
    else if (wr_done && idx == `IDX_CAPT_FLAGS && !pwdata[`CAPT_ERROR_BIT])
      capt_error_r <= 1'b0;
  end
end

////////////////////////////////////////////////////////////////////////////////
// shared output pin

always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
    timer_output_pin <= 1'b0;
  else
  begin
    case (out_mode_r)
      `OUT_TOGGLE:
        if (overflow)
          timer_output_pin <= ~timer_output_pin;
      `OUT_LOW:
        if (overflow)
          timer_output_pin <= 1'b0;
      `OUT_HIGH:
        if (overflow)
          timer_output_pin <= 1'b1;
      `OUT_PWM:
        if (cnt_tick)
          timer_output_pin <= (count_nxt < preset);
      default:
        timer_output_pin <= shared_port_bit;
    endcase
  end
end

endmodule // event_timer_capture_output

// *** event_timer_capture_output_assertions.sv ***
// checker for bus answers, flags and pin of the event timer
module event_timer_capture_output_assertions (
  input wire pclk, // clock
  input wire presetn, // reset
  input wire [7:0] paddr, // address
  input wire psel, // select
  input wire penable, // enable
  input wire pwrite, // direction
  input wire [31:0] pwdata, // write data
  input wire [31:0] prdata, // read data
  input wire pready, // ready
  input wire pslverr, // error
  input wire stop_mode, // stop
  input wire event_trigger_pin, // event pin
  input wire shared_port_bit, // port bit
  input wire timer_output_pin, // pin
  input wire counter_irq_flag // irq flag
);
  logic [3:0] om_r;
  logic [1:0] st_r;
  logic sp_r;
  wire wr_c = psel && penable && pready && pwrite;
  wire port_m = !(om_r inside {4'h1, 4'h2, 4'h3, 4'h4});
  ////////////////////////////////////////////////////////////////
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      om_r <= 4'h0;
      st_r <= 2'h0;
      sp_r <= 1'b0;
    end
    else
    begin
      sp_r <= shared_port_bit;
      if (stop_mode)
        om_r <= 4'h0;
      else if (wr_c && paddr == 8'h54)
        om_r <= pwdata[3:0];
      if (!port_m || stop_mode || shared_port_bit != sp_r || (wr_c && paddr == 8'h54))
        st_r <= 2'h0;
      else if (st_r != 2'h3)
        st_r <= st_r + 2'h1;
    end
  ////////////////////////////////////////////////////////////////
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_wait: assert property ($rose(psel && penable) |-> !pready ##1 pready)
    else $error("ready not after one wait state");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  chk_err_unmapped: assert property (pready |-> pslverr == !(paddr[7:2] inside
    {6'h03, 6'h10, 6'h11, 6'h12, 6'h15, 6'h21, 6'h25, 6'h27}))
    else $error("error flag wrong for address");
  chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  chk_mode_wo: assert property (pready && !pwrite && paddr == 8'h40 |-> prdata == 32'h0)
    else $error("mode register readable");
  chk_outmode_rb: assert property (pready && !pwrite && paddr == 8'h54 |-> prdata[3:0] == om_r)
    else $error("output mode readback wrong");
  chk_reset_low: assert property ($rose(presetn) |-> !timer_output_pin && !counter_irq_flag)
    else $error("outputs not low after reset");
  chk_irq_hold: assert property (counter_irq_flag && !stop_mode && !(wr_c && paddr == 8'h0C)
    |=> counter_irq_flag)
    else $error("irq flag dropped by itself");
  chk_pin_port: assert property (st_r == 2'h3 |-> timer_output_pin == sp_r)
    else $error("pin not following port bit");
  cover property (pslverr);
  cover property ($rose(counter_irq_flag));
  cover property (st_r == 2'h3 && om_r == 4'h8);
endmodule // event_timer_capture_output_assertions

bind event_timer_capture_output event_timer_capture_output_assertions chk (.pclk(pclk),
  .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .stop_mode(stop_mode), .event_trigger_pin(event_trigger_pin),
  .shared_port_bit(shared_port_bit), .timer_output_pin(timer_output_pin),
  .counter_irq_flag(counter_irq_flag));

// *** event_timer_capture_output_tb_top.sv ***
// self-checking bench for the event timer
`include "event_timer_consts.vh"
module event_timer_capture_output_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, stop_mode, shared_port_bit, go, p0;
  logic pready, pslverr, timer_output_pin, counter_irq_flag, event_trigger_pin;
  logic [7:0] paddr, cnt;
  logic [31:0] pwdata, prdata, seed, rv;
  logic [4:0] expq[$];
  logic [3:0] om [3] = '{`OUT_TOGGLE, `OUT_HIGH, `OUT_LOW};
  int bad_count, checks_done;
  event_timer_capture_output dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .stop_mode(stop_mode), .event_trigger_pin(event_trigger_pin),
    .shared_port_bit(shared_port_bit), .timer_output_pin(timer_output_pin),
    .counter_irq_flag(counter_irq_flag));
  event_source src (.pclk(pclk), .go(go), .pin(event_trigger_pin));
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic cmp(string n, logic [4:0] e, logic [4:0] g);
    checks_done++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic xfer(logic [5:0] i, logic w, logic [3:0] d);
    logic [31:0] r;
    r = xs();
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= {i, 2'b00};
    pwrite <= w;
    pwdata <= {r[31:4], d};
    shared_port_bit <= r[4];
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(logic [5:0] i, logic [4:0] e);
    expq.push_back(e);
    xfer(i, 1'b0, 4'h0);
  endtask
  task automatic rdc(logic [7:0] c);
    rd(`IDX_DATA_HIGH, {1'b0, c[7:4]});
    rd(`IDX_DATA_LOW, {1'b0, c[3:0]});
  endtask
  task automatic pulse();
    @(posedge pclk);
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    repeat (30) @(posedge pclk);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite)
      cmp("read", expq.pop_front(), {pslverr, prdata[3:0]});
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial
  begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    end_of_test();
  end
  initial
  begin
    {presetn, psel, penable, pwrite, stop_mode, shared_port_bit, go} = 7'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    seed = 32'h826DED34;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(`IDX_OUT_MODE, 5'h00);
    rd(`IDX_MODE, 5'h00);
    rd(6'h00, 5'h10);
    rv = xs();
    xfer(`IDX_OUT_MODE, 1'b1, rv[3:0]);
    rd(`IDX_OUT_MODE, {1'b0, rv[3:0]});
    xfer(`IDX_OUT_MODE, 1'b1, `OUT_PORT);
    $display("test registers done");
    xfer(`IDX_PORT_FUNC, 1'b1, 4'h2);
    xfer(`IDX_MODE, 1'b1, 4'h7);
    repeat (16) @(posedge pclk);
    xfer(`IDX_DATA_LOW, 1'b1, 4'hE);
    xfer(`IDX_DATA_HIGH, 1'b1, 4'hF);
    cnt = 8'hFE;
    rdc(cnt);
    for (int e = 1; e < 4; e++)
    begin
      xfer(`IDX_EDGE_SEL, 1'b1, 4'(e << 2));
      pulse();
      cnt = cnt + ((e == 3) ? 8'h2 : 8'h1);
      rdc(cnt);
    end
    rd(`IDX_IRQ_FLAG, 5'h01);
    xfer(`IDX_IRQ_FLAG, 1'b1, 4'h0);
    rd(`IDX_IRQ_FLAG, 5'h00);
    $display("test event count done");
    xfer(`IDX_MODE, 1'b1, 4'hF);
    repeat (16) @(posedge pclk);
    xfer(`IDX_DATA_LOW, 1'b1, 4'hF);
    xfer(`IDX_DATA_HIGH, 1'b1, 4'hF);
    xfer(`IDX_EDGE_SEL, 1'b1, 4'h8);
    for (int k = 0; k < 3; k++)
    begin
      xfer(`IDX_OUT_MODE, 1'b1, om[k]);
      repeat (3) @(posedge pclk);
      p0 = timer_output_pin;
      pulse();
      cmp("pin", {4'h0, (k == 0) ? ~p0 : (k == 1)}, {4'h0, timer_output_pin});
      rdc(8'hFF);
    end
    $display("test reload output done");
    xfer(`IDX_MODE, 1'b1, 4'h7);
    repeat (16) @(posedge pclk);
    xfer(`IDX_OUT_MODE, 1'b1, `OUT_PWM);
    xfer(`IDX_DATA_LOW, 1'b1, 4'hF);
    xfer(`IDX_DATA_HIGH, 1'b1, 4'hF);
    pulse();
    cmp("pwm", 5'h01, {4'h0, timer_output_pin});
    xfer(`IDX_DATA_LOW, 1'b1, 4'h0);
    xfer(`IDX_DATA_HIGH, 1'b1, 4'h0);
    pulse();
    cmp("pwm", 5'h00, {4'h0, timer_output_pin});
    $display("test pwm done");
    xfer(`IDX_OUT_MODE, 1'b1, `OUT_CAPTURE);
    xfer(`IDX_MODE, 1'b1, 4'h6);
    repeat (16) @(posedge pclk);
    xfer(`IDX_IRQ_FLAG, 1'b1, 4'h0);
    pulse();
    rd(`IDX_CAPT_FLAGS, 5'h01);
    rd(`IDX_IRQ_FLAG, 5'h01);
    pulse();
    rd(`IDX_CAPT_FLAGS, 5'h03);
    xfer(`IDX_CAPT_FLAGS, 1'b1, 4'h0);
    rd(`IDX_CAPT_FLAGS, 5'h00);
    $display("test capture done");
    stop_mode <= 1'b1;
    repeat (2) @(posedge pclk);
    stop_mode <= 1'b0;
    rd(`IDX_OUT_MODE, 5'h00);
    rd(`IDX_IRQ_FLAG, 5'h00);
    $display("test stop done");
    end_of_test();
  end
endmodule // event_timer_capture_output_tb_top

// *** event_timer_consts.vh ***
// constants for the event timer with capture and output
`ifndef EVENT_TIMER_CONSTS_VH
`define EVENT_TIMER_CONSTS_VH

// register indices, byte address is four times the index
`define IDX_IRQ_FLAG 6'h03
`define IDX_MODE 6'h10
`define IDX_DATA_LOW 6'h11
`define IDX_DATA_HIGH 6'h12
`define IDX_OUT_MODE 6'h15
`define IDX_CAPT_FLAGS 6'h21
`define IDX_PORT_FUNC 6'h25
`define IDX_EDGE_SEL 6'h27

// field positions
`define MODE_RELOAD_BIT 3
`define PORT_EVENT_EN_BIT 1
`define CAPT_STATUS_BIT 0
`define CAPT_ERROR_BIT 1
`define IRQ_FLAG_BIT 0

// clock select codes
`define SEL_EVENT 3'h7

// output mode codes
`define OUT_PORT 4'h0
`define OUT_TOGGLE 4'h1
`define OUT_LOW 4'h2
`define OUT_HIGH 4'h3
`define OUT_PWM 4'h4
`define OUT_CAPTURE 4'h8

// edge select codes in bits 3..2
`define EDGE_NONE 2'h0
`define EDGE_FALL 2'h1
`define EDGE_RISE 2'h2
`define EDGE_BOTH 2'h3

// reset values and count limits
`define MODE_RST 4'h0
`define OUT_MODE_RST 4'h0
`define DATA_LOW_RST 4'h0
`define EDGE_SEL_RST 4'h0
`define PORT_FUNC_RST 4'h0
`define COUNT_MAX 8'hFF
`define COUNT_ZERO 8'h00

// timing
`define CLK_NS 10
`define TCYC_NS 40
`define TCYC_DIV (`TCYC_NS / `CLK_NS)
// last phase of the instruction cycle divider, TCYC_DIV minus one
`define TCYC_LAST 2'h3
`define MODE_DELAY_TCYC 2'h2

`endif
